/* File: isd_pkg.sv */
// Package for the input source detect and start-up block
`default_nettype none
package isd_pkg;
  // Current limit codes, 20 mA per lsb
  localparam int EXTERNAL_CURRENT_LIMIT_PIN_W = 8;
  localparam logic [7:0] EXTERNAL_CURRENT_LIMIT_PIN_MIN = 8'h05;
  localparam logic [7:0] EXTERNAL_CURRENT_LIMIT_PIN_RST = 8'h19;
  localparam logic [7:0] EXTERNAL_CURRENT_LIMIT_PIN_500MA = 8'h19;
  localparam logic [7:0] EXTERNAL_CURRENT_LIMIT_PIN_1A = 8'h32;
  localparam logic [7:0] EXTERNAL_CURRENT_LIMIT_PIN_1A5 = 8'h4b;
  localparam logic [7:0] EXTERNAL_CURRENT_LIMIT_PIN_2A1 = 8'h69;
  localparam logic [7:0] EXTERNAL_CURRENT_LIMIT_PIN_2A4 = 8'h78;
  // Voltage codes, 40 mV per lsb
  localparam logic [8:0] VLIM_RST = 9'h073;
  localparam logic [8:0] VLIM_MIN = 9'h05f;
  localparam logic [8:0] VLIM_MAX = 9'h1a4;
  localparam logic [8:0] VTRACK_OFS = 9'h00a;
  localparam logic [8:0] MIN_SYSTEM_VOLTAGE_RST = 9'h058;
  localparam logic [8:0] VSYS_ABOVE_BAT = 9'h001;
  // Source type status codes
  localparam logic [2:0] ST_NONE = 3'h0;
  localparam logic [2:0] ST_SDP = 3'h1;
  localparam logic [2:0] ST_CDP = 3'h2;
  localparam logic [2:0] ST_DCP = 3'h3;
  localparam logic [2:0] ST_UNK = 3'h4;
  localparam logic [2:0] ST_DIV = 3'h5;
  localparam logic [2:0] ST_HIGH_VOLTAGE_CHARGING_PORT = 3'h6;
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int DCD_TIMEOUT_MS = 500;
  localparam int DCD_CYCLES = DCD_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int SS_STEP_CYCLES = 16;
  // Register offsets
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_EXTERNAL_CURRENT_LIMIT_PIN = 12'h004;
  localparam logic [11:0] A_VLIM = 12'h008;
  localparam logic [11:0] A_VSYS = 12'h00c;
  localparam logic [11:0] A_STAT = 12'h010;
  localparam logic [11:0] A_EFF = 12'h014;
  // Control bit positions
  localparam int B_AUTO = 0;
  localparam int B_FORCE = 1;
  localparam int B_EN9 = 2;
  localparam int B_EN12 = 3;
  localparam int B_DCPB = 4;
  localparam int B_HIZ = 5;
  localparam int B_EXTL = 6;
  localparam int B_TRACK = 7;
  localparam int B_PFMB = 8;
  localparam int B_PFMO = 9;
  localparam int B_CHG = 10;
  localparam logic [10:0] CTRL_RST = 11'h441;
  typedef enum logic [6:0] {
    ISD_IDLE = 7'h01, ISD_DCD = 7'h02, ISD_PRI = 7'h04, ISD_SEC = 7'h08,
    ISD_HV = 7'h10, ISD_NSTD = 7'h20, ISD_DONE = 7'h40
  } isd_state_t;
endpackage : isd_pkg
`default_nettype wire

/* File: isd_core.sv */
// Input source detection, limits and converter start-up control
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module isd_core
  import isd_pkg::*;
#(
  parameter int DCD_TICKS = DCD_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bias_reg_up,
  input wire logic source_qualified,
  input wire logic vbus_present,
  input wire logic dcd_contact,
  input wire logic port_sdp,
  input wire logic port_cdp,
  input wire logic port_dcp,
  input wire logic dp_in_2p0,
  input wire logic dp_in_2p8,
  input wire logic dm_in_2p0,
  input wire logic dm_in_2p8,
  input wire logic hv_port_ack,
  input wire logic [7:0] external_current_limit_pin,
  input wire logic [8:0] vbat_code,
  input wire logic vbus_above_sleep,
  input wire logic vbus_below_ovp,
  input wire logic vsys_below_ovp,
  input wire logic tj_below_shut,
  input wire logic light_load,
  input wire logic boost_mode,
  input wire logic charge_done,
  output logic dp_src_0p6,
  output logic dp_hv_bias,
  output logic dm_hv_bias,
  output logic [1:0] hv_level,
  output logic detect_busy,
  output logic converter_enable,
  output logic battery_switch,
  output logic pfm_mode,
  output logic [7:0] eff_current_limit,
  output logic [8:0] eff_voltage_limit,
  output logic [8:0] sys_reg_target
);
  logic [10:0] ctrl_q;
  logic [7:0] external_current_limit_pin_q, external_current_limit_pin_d;
  logic [8:0] vlim_q;
  logic [8:0] vsys_q;
  logic [2:0] stat_q, stat_d;
  isd_state_t st_q, st_d;
  logic [31:0] tmr_q;
  logic vbus_q;
  logic [7:0] ss_q;
  logic [4:0] ss_cnt_q;
  logic conv_q;

  wire wr = psel && penable && pwrite;
  wire rd_hit_ctrl = paddr == A_CTRL;
  wire hit = rd_hit_ctrl || paddr == A_EXTERNAL_CURRENT_LIMIT_PIN || paddr == A_VLIM || paddr == A_VSYS
             || paddr == A_STAT || paddr == A_EFF;
  wire auto_en = ctrl_q[B_AUTO];
  wire hv_req = ctrl_q[B_EN9] || ctrl_q[B_EN12];
  wire hiz = ctrl_q[B_HIZ];
  wire force_wr = wr && paddr == A_CTRL && pwdata[B_FORCE];
  wire plug_evt = vbus_present && !vbus_q;
  wire gate_ok = bias_reg_up && source_qualified;
  // Forced runs ignore the auto bit, plug-ins need it
  wire start = gate_ok && ((auto_en && plug_evt) || force_wr);
  wire tmo = tmr_q >= DCD_TICKS - 1;
  wire div1 = dp_in_2p0 && dm_in_2p8;
  wire div2 = dp_in_2p8 && dm_in_2p0;
  wire div3 = dp_in_2p8 && dm_in_2p8;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_comb begin
    st_d = st_q;
    external_current_limit_pin_d = external_current_limit_pin_q;
    stat_d = stat_q;
    case (st_q)
      ISD_IDLE: if (start) st_d = ISD_DCD;
      ISD_DCD: begin
        if (dcd_contact) st_d = ISD_PRI;
        else if (tmo) st_d = ISD_NSTD;
      end
      ISD_PRI: begin
        if (port_cdp || port_dcp) st_d = ISD_SEC;
        else if (port_sdp) begin
          st_d = ISD_DONE;
          external_current_limit_pin_d = EXTERNAL_CURRENT_LIMIT_PIN_500MA;
          stat_d = ST_SDP;
        end else st_d = ISD_NSTD;
      end
      ISD_SEC: begin
        if (port_dcp && hv_req) st_d = ISD_HV;
        else begin
          st_d = ISD_DONE;
          external_current_limit_pin_d = EXTERNAL_CURRENT_LIMIT_PIN_1A5;
          stat_d = port_dcp ? ST_DCP : ST_CDP;
        end
      end
      ISD_HV: begin
        st_d = ISD_DONE;
        external_current_limit_pin_d = EXTERNAL_CURRENT_LIMIT_PIN_1A5;
        stat_d = hv_port_ack ? ST_HIGH_VOLTAGE_CHARGING_PORT : ST_DCP;
      end
      ISD_NSTD: begin
        st_d = ISD_DONE;
        stat_d = (div1 || div2 || div3) ? ST_DIV : ST_UNK;
        external_current_limit_pin_d = div3 ? EXTERNAL_CURRENT_LIMIT_PIN_2A4 : div2 ? EXTERNAL_CURRENT_LIMIT_PIN_2A1 : div1 ? EXTERNAL_CURRENT_LIMIT_PIN_1A : EXTERNAL_CURRENT_LIMIT_PIN_500MA;
      end
      ISD_DONE: st_d = ISD_IDLE;
      default: st_d = ISD_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ISD_IDLE;
      tmr_q <= '0;
      vbus_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= (st_q == ISD_DCD) ? tmr_q + 32'd1 : '0;
      vbus_q <= vbus_present;
    end
  end

  // Detection result wins over a host write in the same cycle
  wire det_load = st_q != ISD_IDLE && st_q != ISD_DONE && st_d == ISD_DONE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      external_current_limit_pin_q <= EXTERNAL_CURRENT_LIMIT_PIN_RST;
      vlim_q <= VLIM_RST;
      vsys_q <= MIN_SYSTEM_VOLTAGE_RST;
      stat_q <= ST_NONE;
    end else begin
      if (wr && paddr == A_CTRL) ctrl_q <= pwdata[10:0] & ~(11'h001 << B_FORCE);
      if (det_load) begin
        external_current_limit_pin_q <= external_current_limit_pin_d;
        stat_q <= stat_d;
      end else if (wr && paddr == A_EXTERNAL_CURRENT_LIMIT_PIN) external_current_limit_pin_q <= pwdata[7:0];
      if (wr && paddr == A_VLIM) begin
        if (pwdata[8:0] < VLIM_MIN) vlim_q <= VLIM_MIN;
        else if (pwdata[8:0] > VLIM_MAX) vlim_q <= VLIM_MAX;
        else vlim_q <= pwdata[8:0];
      end
      if (wr && paddr == A_VSYS) vsys_q <= pwdata[8:0];
    end
  end

  wire [7:0] lim_cap = (ctrl_q[B_EXTL] && external_current_limit_pin < external_current_limit_pin_q)
                       ? external_current_limit_pin : external_current_limit_pin_q;
  wire [8:0] track = vbat_code + VTRACK_OFS;
  wire conv_ok = source_qualified && vbus_above_sleep && vbus_below_ovp && !hiz
                 && vsys_below_ovp && tj_below_shut && !detect_busy;

  // Soft start ramps one code per step period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_q <= 1'b0;
      ss_q <= EXTERNAL_CURRENT_LIMIT_PIN_MIN;
      ss_cnt_q <= '0;
    end else begin
      conv_q <= conv_ok;
      ss_cnt_q <= (ss_cnt_q == 5'(SS_STEP_CYCLES - 1)) ? 5'd0 : ss_cnt_q + 5'd1;
      if (!conv_q) ss_q <= EXTERNAL_CURRENT_LIMIT_PIN_MIN;
      else if (ss_q > lim_cap) ss_q <= lim_cap;
      else if (ss_q < lim_cap && ss_cnt_q == 5'(SS_STEP_CYCLES - 1)) ss_q <= ss_q + 8'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eff_current_limit <= EXTERNAL_CURRENT_LIMIT_PIN_MIN;
      eff_voltage_limit <= VLIM_RST;
      sys_reg_target <= MIN_SYSTEM_VOLTAGE_RST;
      prdata <= '0;
    end else begin
      eff_current_limit <= conv_q ? ss_q : lim_cap;
      eff_voltage_limit <= (ctrl_q[B_TRACK] && track > vlim_q) ? track : vlim_q;
      sys_reg_target <= ((!ctrl_q[B_CHG] && vbat_code > vsys_q) || charge_done)
                        ? vbat_code + VSYS_ABOVE_BAT : vsys_q;
      case (paddr)
        A_CTRL: prdata <= {21'h0, ctrl_q};
        A_EXTERNAL_CURRENT_LIMIT_PIN: prdata <= {24'h0, external_current_limit_pin_q};
        A_VLIM: prdata <= {23'h0, vlim_q};
        A_VSYS: prdata <= {23'h0, vsys_q};
        A_STAT: prdata <= {28'h0, detect_busy, stat_q};
        A_EFF: prdata <= {15'h0, eff_voltage_limit, eff_current_limit};
        default: prdata <= '0;
      endcase
    end
  end

  wire hv_on = stat_q == ST_HIGH_VOLTAGE_CHARGING_PORT && hv_req && !hiz;
  assign detect_busy = st_q != ISD_IDLE;
  assign dp_src_0p6 = stat_q == ST_DCP && ctrl_q[B_DCPB] && !hiz;
  assign dp_hv_bias = hv_on;
  assign dm_hv_bias = hv_on;
  assign hv_level = hv_on ? (ctrl_q[B_EN12] ? 2'h2 : 2'h1) : 2'h0;
  assign converter_enable = conv_q;
  assign battery_switch = !conv_q || ctrl_q[B_CHG];
  assign pfm_mode = conv_q && light_load
                    && !(boost_mode ? ctrl_q[B_PFMO] : ctrl_q[B_PFMB]);

  // Detection walk steps shared by the checks below
  sequence s_stay_idle;
    st_q == ISD_IDLE;
  endsequence
  sequence s_enter_dcd;
    st_q == ISD_DCD;
  endsequence
  sequence s_result_held;
    st_q == ISD_DONE ##1 st_q == ISD_IDLE;
  endsequence

  property p_force_starts;
    @(posedge pclk) disable iff (!presetn)
    (force_wr && gate_ok && st_q == ISD_IDLE) |=> s_enter_dcd;
  endproperty
  a_force_starts: assert property (p_force_starts) else $error("force ignored");
  property p_noauto;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ISD_IDLE && !auto_en && !force_wr) |=> s_stay_idle;
  endproperty
  a_noauto: assert property (p_noauto) else $error("auto off ran");
  property p_gate;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ISD_IDLE && !gate_ok) |=> s_stay_idle;
  endproperty
  a_gate: assert property (p_gate) else $error("ungated start");
  property p_qual;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ISD_IDLE && !source_qualified) |=> s_stay_idle;
  endproperty
  a_qual: assert property (p_qual) else $error("unqualified start");
  property p_hiz;
    @(posedge pclk) disable iff (!presetn)
    hiz |-> !dp_src_0p6 && !dp_hv_bias && !dm_hv_bias;
  endproperty
  a_hiz: assert property (p_hiz) else $error("hiz bias");
  property p_conv;
    @(posedge pclk) disable iff (!presetn)
    $rose(converter_enable) |-> $past(conv_ok);
  endproperty
  a_conv: assert property (p_conv) else $error("bad converter start");
  property p_ss;
    @(posedge pclk) disable iff (!presetn)
    $rose(converter_enable) |=> eff_current_limit == EXTERNAL_CURRENT_LIMIT_PIN_MIN;
  endproperty
  a_ss: assert property (p_ss) else $error("no soft start");
  property p_hvoff;
    @(posedge pclk) disable iff (!presetn)
    !hv_req |-> !dm_hv_bias && !dp_hv_bias && hv_level == 2'h0;
  endproperty
  a_hvoff: assert property (p_hvoff) else $error("hv bias held");
  property p_load;
    @(posedge pclk) disable iff (!presetn)
    det_load |=> stat_q == $past(stat_d) && external_current_limit_pin_q == $past(external_current_limit_pin_d);
  endproperty
  a_load: assert property (p_load) else $error("no load");
  property p_done_idle;
    @(posedge pclk) disable iff (!presetn)
    det_load |=> s_result_held;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("detection did not finish");
  property p_plug_starts;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ISD_IDLE && gate_ok && auto_en && plug_evt) |=> s_enter_dcd;
  endproperty
  a_plug_starts: assert property (p_plug_starts) else $error("plug-in ignored");
  property p_external_current_limit_pin_hold;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ISD_IDLE && !(wr && paddr == A_EXTERNAL_CURRENT_LIMIT_PIN)) |=> $stable(external_current_limit_pin_q);
  endproperty
  a_external_current_limit_pin_hold: assert property (p_external_current_limit_pin_hold) else $error("current limit changed");
  property p_tmo_nstd;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ISD_DCD && !dcd_contact && tmo) |=> st_q == ISD_NSTD;
  endproperty
  a_tmo_nstd: assert property (p_tmo_nstd) else $error("timeout not taken");
  property p_dcd_wait;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ISD_DCD && !dcd_contact && !tmo) |=> s_enter_dcd;
  endproperty
  a_dcd_wait: assert property (p_dcd_wait) else $error("contact wait left early");
  property p_hv_gate;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ISD_SEC && !hv_req) |=> st_q == ISD_DONE;
  endproperty
  a_hv_gate: assert property (p_hv_gate) else $error("hv detection unrequested");
  property p_dp_bias;
    @(posedge pclk) disable iff (!presetn)
    (stat_q == ST_DCP && !hiz) |-> dp_src_0p6 == ctrl_q[B_DCPB];
  endproperty
  a_dp_bias: assert property (p_dp_bias) else $error("dp source wrong");
  property p_hv_hold;
    @(posedge pclk) disable iff (!presetn)
    (stat_q == ST_HIGH_VOLTAGE_CHARGING_PORT && hv_req && !hiz) |-> dp_hv_bias && dm_hv_bias;
  endproperty
  a_hv_hold: assert property (p_hv_hold) else $error("hv bias dropped");
  property p_ext_cap;
    @(posedge pclk) disable iff (!presetn)
    (!conv_q && ctrl_q[B_EXTL]) |=> eff_current_limit <= $past(external_current_limit_pin)
      && eff_current_limit <= $past(external_current_limit_pin_q);
  endproperty
  a_ext_cap: assert property (p_ext_cap) else $error("pin clamp missed");
  property p_ss_step;
    @(posedge pclk) disable iff (!presetn)
    (conv_q && ss_q < lim_cap) |=> ss_q == $past(ss_q) || ss_q == $past(ss_q) + 8'd1;
  endproperty
  a_ss_step: assert property (p_ss_step) else $error("soft start skipped a code");
  property p_vlim_range;
    @(posedge pclk) disable iff (!presetn)
    vlim_q >= VLIM_MIN && vlim_q <= VLIM_MAX;
  endproperty
  a_vlim_range: assert property (p_vlim_range) else $error("voltage limit out of range");
  property p_track;
    @(posedge pclk) disable iff (!presetn)
    ctrl_q[B_TRACK] |=> eff_voltage_limit >= $past(vlim_q);
  endproperty
  a_track: assert property (p_track) else $error("tracking below register");
  property p_bsw;
    @(posedge pclk) disable iff (!presetn)
    conv_q |-> battery_switch == ctrl_q[B_CHG];
  endproperty
  a_bsw: assert property (p_bsw) else $error("battery switch wrong");
  property p_pfm;
    @(posedge pclk) disable iff (!presetn)
    (boost_mode ? ctrl_q[B_PFMO] : ctrl_q[B_PFMB]) |-> !pfm_mode;
  endproperty
  a_pfm: assert property (p_pfm) else $error("light load mode not disabled");
  property p_sysmin;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_q[B_CHG] && !charge_done) |=> sys_reg_target == $past(vsys_q);
  endproperty
  a_sysmin: assert property (p_sysmin) else $error("system target wrong");
  property p_nstd_div;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ISD_NSTD && div3) |=> external_current_limit_pin_q == EXTERNAL_CURRENT_LIMIT_PIN_2A4 && stat_q == ST_DIV;
  endproperty
  a_nstd_div: assert property (p_nstd_div) else $error("divider limit wrong");
  property p_sdp;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ISD_PRI && port_sdp && !port_cdp && !port_dcp) |=> stat_q == ST_SDP && external_current_limit_pin_q == EXTERNAL_CURRENT_LIMIT_PIN_500MA;
  endproperty
  a_sdp: assert property (p_sdp) else $error("sdp result wrong");
endmodule : isd_core
`default_nettype wire

/* File: isd_port_model.sv */
// Far-side model: USB port or adapter seen through the D+/D- comparators
`timescale 1ns/1ps
`default_nettype none
module isd_port_model (
  input wire logic [2:0] kind,
  input wire logic hv_capable,
  output logic dcd_contact,
  output logic port_sdp,
  output logic port_cdp,
  output logic port_dcp,
  output logic dp_in_2p0,
  output logic dp_in_2p8,
  output logic dm_in_2p0,
  output logic dm_in_2p8,
  output logic hv_port_ack
);
  // Kind 0 none, 1 sdp, 2 cdp, 3 dcp, 4 unknown, 5 to 7 dividers 1 to 3
  assign dcd_contact = kind inside {3'h1, 3'h2, 3'h3};
  assign port_sdp = kind == 3'h1;
  assign port_cdp = kind == 3'h2;
  assign port_dcp = kind == 3'h3;
  // Dividers never make contact, so only the timeout path reaches them
  assign dp_in_2p0 = kind == 3'h5;
  assign dp_in_2p8 = kind inside {3'h6, 3'h7};
  assign dm_in_2p0 = kind == 3'h6;
  assign dm_in_2p8 = kind inside {3'h5, 3'h7};
  assign hv_port_ack = hv_capable && kind == 3'h3;
endmodule : isd_port_model
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the source detect and start-up block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import isd_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic vbus = 0, hv_cap = 0, ok = 1, light = 0;
  logic [2:0] kind = 3'h0;
  logic [7:0] ext_pin = 8'hff, iv = 8'h19, eff_i;
  logic [8:0] vbat = 9'h0a0, eff_v, sys_t;
  logic dcd_contact, port_sdp, port_cdp, port_dcp, dp_in_2p0, dp_in_2p8, dm_in_2p0, dm_in_2p8, hv_port_ack;
  logic src06, dpb, dmb, busy, conv, bsw, pfm;
  logic [1:0] hvl;
  logic [32:0] exp_q[$];
  int n_errors = 0, check_count = 0;
  logic [2:0] t_kind[10] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h3, 3'h3, 3'h3};
  logic [3:0] t_en[10] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h8};
  logic [2:0] t_st[10] = '{ST_SDP, ST_CDP, ST_DCP, ST_UNK, ST_DIV, ST_DIV, ST_DIV, ST_DCP, ST_HIGH_VOLTAGE_CHARGING_PORT, ST_HIGH_VOLTAGE_CHARGING_PORT};
  logic [7:0] t_il[10] = '{EXTERNAL_CURRENT_LIMIT_PIN_500MA, EXTERNAL_CURRENT_LIMIT_PIN_1A5, EXTERNAL_CURRENT_LIMIT_PIN_1A5, EXTERNAL_CURRENT_LIMIT_PIN_500MA, EXTERNAL_CURRENT_LIMIT_PIN_1A, EXTERNAL_CURRENT_LIMIT_PIN_2A1, EXTERNAL_CURRENT_LIMIT_PIN_2A4, EXTERNAL_CURRENT_LIMIT_PIN_1A5,
    EXTERNAL_CURRENT_LIMIT_PIN_1A5, EXTERNAL_CURRENT_LIMIT_PIN_1A5};
  isd_core #(.DCD_TICKS(50)) u_isd_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bias_reg_up(ok), .source_qualified(ok), .vbus_present(vbus), .dcd_contact, .port_sdp,
    .port_cdp, .port_dcp, .dp_in_2p0, .dp_in_2p8, .dm_in_2p0, .dm_in_2p8, .hv_port_ack,
    .external_current_limit_pin(ext_pin), .vbat_code(vbat), .vbus_above_sleep(ok), .vbus_below_ovp(ok),
    .vsys_below_ovp(ok), .tj_below_shut(ok), .light_load(light), .boost_mode(1'b0), .charge_done(1'b0),
    .dp_src_0p6(src06), .dp_hv_bias(dpb), .dm_hv_bias(dmb), .hv_level(hvl), .detect_busy(busy),
    .converter_enable(conv), .battery_switch(bsw), .pfm_mode(pfm), .eff_current_limit(eff_i),
    .eff_voltage_limit(eff_v), .sys_reg_target(sys_t));
  isd_port_model u_isd_port_model (.kind, .hv_capable(hv_cap), .dcd_contact, .port_sdp, .port_cdp, .port_dcp,
    .dp_in_2p0, .dp_in_2p8, .dm_in_2p0, .dm_in_2p8, .hv_port_ack);
  initial forever #12.5 pclk = ~pclk;
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] expv);
    check_count++;
    if (seen !== expv) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, expv, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  // Reads note their expectation; the monitor below compares it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    if (!wr) exp_q.push_back({a > A_EFF, d});
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
  endtask : settle
  task automatic wait_done;
    int n = 0;
    while (busy !== 1'b0 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    if (n == 500) check("detect finish", 33'h0, 33'h1);
  endtask : wait_done
  task automatic detect(input logic [2:0] k, input logic [31:0] c);
    kind <= k;
    apb(1, A_CTRL, c);
    wait_done();
  endtask : detect
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) check("unnoted read", 33'h0, 33'h1);
      else check("apb read", {pslverr, prdata}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    $display("watchdog expired");
    report_and_stop();
  end
  initial begin
    void'($urandom(38));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, A_CTRL, 32'h441);
    apb(0, A_VLIM, 32'(VLIM_RST));
    apb(0, A_VSYS, 32'(MIN_SYSTEM_VOLTAGE_RST));
    apb(0, 12'h018, 32'h0);
    kind <= 3'h1;
    vbus <= 1;
    settle(3);
    wait_done();
    apb(0, A_STAT, 32'(ST_SDP));
    apb(0, A_EXTERNAL_CURRENT_LIMIT_PIN, 32'(EXTERNAL_CURRENT_LIMIT_PIN_500MA));
    done("reset and plug-in");
    for (int i = 0; i < 10; i++) begin
      hv_cap <= i > 6;
      detect(t_kind[i], 32'h403 | 32'(t_en[i]));
      apb(0, A_STAT, 32'(t_st[i]));
      apb(0, A_EXTERNAL_CURRENT_LIMIT_PIN, 32'(t_il[i]));
      if (i > 7) check("hv bias", 33'({dpb, dmb, hvl}), 33'({2'b11, t_en[i][3:2]}));
    end
    apb(1, A_CTRL, 32'h401);
    check("hv bias off", 33'({dpb, dmb}), 33'h0);
    done("source types");
    detect(3'h3, 32'h403);
    apb(0, A_STAT, 32'(ST_DCP));
    for (int j = 0; j < 3; j++) begin
      apb(1, A_CTRL, j == 0 ? 32'h411 : j == 1 ? 32'h431 : 32'h401);
      check("dp source", 33'(src06), 33'(j == 0));
    end
    done("port bias");
    iv = 8'($urandom_range(255, 5));
    apb(1, A_CTRL, 32'h400);
    apb(1, A_EXTERNAL_CURRENT_LIMIT_PIN, 32'(iv));
    kind <= 3'h2;
    vbus <= 0;
    settle(3);
    vbus <= 1;
    settle(80);
    check("busy", 33'(busy), 33'h0);
    apb(0, A_EXTERNAL_CURRENT_LIMIT_PIN, 32'(iv));
    apb(0, A_STAT, 32'(ST_DCP));
    settle(4200);
    check("eff external_current_limit_pin", 33'(eff_i), 33'(iv));
    ext_pin <= 8'($urandom);
    apb(1, A_CTRL, 32'h440);
    settle(4200);
    check("eff external_current_limit_pin pin", 33'(eff_i), 33'(ext_pin < iv ? ext_pin : iv));
    done("limits");
    vbat <= 9'($urandom_range(336, 96));
    light <= 1;
    apb(1, A_CTRL, 32'h0c0);
    settle(4);
    check("eff vlim", 33'(eff_v), 33'(vbat + VTRACK_OFS > VLIM_RST ? vbat + VTRACK_OFS : VLIM_RST));
    check("path", 33'({conv, bsw, pfm, sys_t}), 33'({3'b101, vbat + VSYS_ABOVE_BAT}));
    apb(1, A_CTRL, 32'h1c0);
    check("pfm off", 33'(pfm), 33'h0);
    ok <= 0;
    apb(1, A_CTRL, 32'h403);
    settle(3);
    check("gated", 33'({busy, conv}), 33'h0);
    ok <= 1;
    settle(3);
    wait_done();
    settle(3);
    check("conv on", 33'(conv), 33'h1);
    check("path chg", 33'({bsw, sys_t}), 33'({1'b1, MIN_SYSTEM_VOLTAGE_RST}));
    done("start-up gating");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
